/* File: bench/mem_model.sv */
// Data and program memories that answer one cycle after a read strobe.
// Assumes strobes on mclk; contents are a fixed function of the address.
`timescale 1ns/100ps
module mem_model #(
  parameter logic [7:0] FILL_HI = 8'h3c // Arbitrary upper-byte fill value.
) (
  input mclk,
  input dmem_req,
  input [15:0] dmem_addr,
  output logic [15:0] dmem_rdata,
  input pmem_req,
  input [22:0] pmem_addr,
  output logic [23:0] pmem_rdata
);
  // ==========
  // Read ports; idle lines toggle, so stale data returns only on every second idle cycle.
  always @(posedge mclk) begin
    dmem_rdata <= dmem_req ? ~dmem_addr : ~dmem_rdata;
    pmem_rdata <= pmem_req ? {FILL_HI, pmem_addr[15:0] ^ {pmem_addr[22:15], 8'h00}}
                           : ~pmem_rdata;
  end
endmodule : mem_model

/* File: bench/testbench.sv */
// Self-checking bench for the program-space data window.
// Assumes the memory model on the far side and the bound checker.
`timescale 1ns/100ps
module testbench;
  import window_pkg::*;
  typedef struct packed {logic [15:0] data; logic prog; logic xs; logic [2:0] lat;} note_t;
  logic mclk = 0, reset_n = 0, window_en = 0, table_busy = 0, cpu_req = 0, light_ins = 0;
  logic in_repeat = 0, rpt_first = 0, rpt_last = 0, rpt_irq_exit = 0, rpt_irq_reenter = 0;
  logic [PAGE_W-1:0] window_page = 8'h00;
  logic [DATA_AW-1:0] cpu_addr = 16'h0000, dmem_addr;
  logic cpu_busy, cpu_ack, cpu_xspace, cpu_from_prog, dmem_req, pmem_req;
  logic [DATA_W-1:0] cpu_rdata, dmem_rdata;
  logic [PROG_AW-1:0] pmem_addr;
  logic [PROG_W-1:0] pmem_rdata;
  note_t notes[$];
  note_t n;
  int err_total = 0, samples_checked = 0, t = 0;
  logic [31:0] rng = 32'h4e;
  always #12.5 mclk = ~mclk;
  program_space_data_window i_program_space_data_window (
    .mclk, .reset_n, .window_en, .window_page, .table_busy, .cpu_req, .cpu_addr,
    .light_ins, .in_repeat, .rpt_first, .rpt_last, .rpt_irq_exit, .rpt_irq_reenter,
    .cpu_busy, .cpu_ack, .cpu_rdata, .cpu_xspace, .cpu_from_prog, .dmem_req,
    .dmem_addr, .dmem_rdata, .pmem_req, .pmem_addr, .pmem_rdata);
  mem_model i_mem_model (.mclk, .dmem_req, .dmem_addr, .dmem_rdata, .pmem_req,
    .pmem_addr, .pmem_rdata);
  // ==========
  // Helpers.
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic check(logic [15:0] seen, logic [15:0] exp, string what);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // Modes: 0 light, 1 heavy, 2-5 repeat edges, 6 repeat middle, 7 table, 8 off.
  task automatic access(int mode, logic hi);
    logic [15:0] a;
    logic [7:0] pg;
    logic hit;
    logic [2:0] e;
    rng = xs(rng);
    a = rng[15:0] | {hi, 15'h0000};
    pg = rng[23:16];
    hit = a[15] && mode < 7;
    e = (!hit || mode == 6) ? 3'h0 : (mode == 0) ? 3'h1 : 3'h2;
    notes.push_back({hit ? {pg[0], a[14:0]} ^ {pg, 8'h00} : ~a, hit, a[15], 3'(3'h2 + e)});
    @(posedge mclk);
    cpu_req <= 1'b1;
    cpu_addr <= a;
    window_page <= pg;
    window_en <= mode != 8;
    table_busy <= mode == 7;
    light_ins <= mode == 0;
    in_repeat <= mode > 1 && mode < 7;
    {rpt_first, rpt_last, rpt_irq_exit, rpt_irq_reenter} <= (mode > 1 && mode < 6) ?
      4'h8 >> (mode - 2) : 4'h0;
    // Request stays up one busy cycle and must be ignored.
    repeat (2) @(posedge mclk);
    cpu_req <= 1'b0;
    for (int k = 0; k < 8 && cpu_ack !== 1'b1; k++) @(posedge mclk);
  endtask : access
  // ==========
  // Result watcher.
  always @(posedge mclk) begin
    t++;
    if (cpu_ack === 1'b1) begin
      n = notes.pop_front();
      check(cpu_rdata, n.data, "read data");
      check(16'(cpu_from_prog), 16'(n.prog), "source");
      check(16'(cpu_xspace), 16'(n.xs), "x space flag");
      check(16'(t), 16'(n.lat), "lat");
    end
    if (cpu_req && !cpu_busy) t = 0;
  end
  initial begin
    repeat (2000) @(posedge mclk);
    err_total++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 9; i++) access(i, 1'b1);
    $display("directed modes done");
    for (int i = 0; i < 60; i++) access(int'(rng[31:28]) % 9, 1'b0);
    repeat (4) @(posedge mclk);
    check(16'(notes.size()), 16'h0000, "unanswered requests");
    $display("random accesses done");
    tally_and_finish();
  end
endmodule : testbench

/* File: bench/window_sva.sv */
// Checker for the program-space data window, bound to its top module.
// Assumes only the top module's ports and a single clock domain.
`timescale 1ns/100ps
module window_sva (
  input mclk,
  input reset_n,
  input window_en,
  input [7:0] window_page,
  input table_busy,
  input cpu_req,
  input [15:0] cpu_addr,
  input light_ins,
  input in_repeat,
  input rpt_first,
  input rpt_last,
  input rpt_irq_exit,
  input rpt_irq_reenter,
  input cpu_busy,
  input cpu_ack,
  input [15:0] cpu_rdata,
  input cpu_xspace,
  input cpu_from_prog,
  input dmem_req,
  input [15:0] dmem_rdata,
  input pmem_req,
  input [22:0] pmem_addr,
  input [23:0] pmem_rdata
);
  // ==========
  // Assertions.
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire take = cpu_req && !cpu_busy;
  wire hit = take && cpu_addr[15] && window_en && !table_busy;
  wire rpt_edge = rpt_first || rpt_last || rpt_irq_exit || rpt_irq_reenter;
  a_plain_fast: assert property (take && !hit |-> ##2 cpu_ack && !cpu_from_prog)
    else $error("plain access latency wrong");
  a_busy_span: assert property (take && !hit |=> cpu_busy ##1 !cpu_busy)
    else $error("data access busy span wrong");
  a_light_one: assert property (
    hit && !in_repeat && light_ins |-> ##1 !cpu_ack [*2] ##1 cpu_ack)
    else $error("light window access latency wrong");
  a_heavy_two: assert property (hit && !in_repeat && !light_ins |-> ##4 cpu_ack)
    else $error("heavy window access latency wrong");
  a_rpt_edge: assert property (hit && in_repeat && rpt_edge |-> ##4 cpu_ack)
    else $error("repeat edge latency wrong");
  a_rpt_fast: assert property (hit && in_repeat && !rpt_edge |-> ##2 cpu_ack)
    else $error("repeat middle latency wrong");
  a_page_addr: assert property (
    hit |-> pmem_req && pmem_addr == {window_page, cpu_addr[14:0]})
    else $error("program address wrong");
  a_table_hold: assert property (take && table_busy |-> dmem_req && !pmem_req)
    else $error("window not suspended");
  a_xspace_bit: assert property (take |=> cpu_xspace == $past(cpu_addr[15]))
    else $error("x space flag wrong");
  a_low_word: assert property (
    cpu_ack |-> cpu_rdata == (cpu_from_prog ? $past(pmem_rdata[15:0]) : $past(dmem_rdata)))
    else $error("read data wrong");
  c_rpt: cover property (hit && in_repeat);
  c_table: cover property (take && table_busy && cpu_addr[15]);
  c_prog: cover property (cpu_ack && cpu_from_prog);
endmodule : window_sva

bind program_space_data_window window_sva i_window_sva (.*);

/* File: common/win_if.sv */
// Interface between the window controller and its address mapper.
// Assumes both ends sit in the instruction clock domain; it carries no state.
`timescale 1ns/100ps
interface win_if;
  import window_pkg::*;

  logic [DATA_AW-1:0] addr;
  logic win_en;
  logic [PAGE_W-1:0] page;
  logic table_busy;
  logic light_ins;
  logic in_repeat;
  logic rpt_first;
  logic rpt_last;
  logic rpt_irq_exit;
  logic rpt_irq_reenter;
  logic hit;
  logic [PROG_AW-1:0] prog_addr;
  logic [CNT_W-1:0] extra;

  modport core (
    output addr,
    output win_en,
    output page,
    output table_busy,
    output light_ins,
    output in_repeat,
    output rpt_first,
    output rpt_last,
    output rpt_irq_exit,
    output rpt_irq_reenter,
    input hit,
    input prog_addr,
    input extra
  );

  modport map (
    input addr,
    input win_en,
    input page,
    input table_busy,
    input light_ins,
    input in_repeat,
    input rpt_first,
    input rpt_last,
    input rpt_irq_exit,
    input rpt_irq_reenter,
    output hit,
    output prog_addr,
    output extra
  );
endinterface : win_if

/* File: common/window_pkg.sv */
// Constants and types shared by the program-space data window and its address mapper.
// Assumes one instruction clock and a synchronous program memory read port.
package window_pkg;

  // ==========================================================================
  // Widths.
  localparam int DATA_AW = 16;
  localparam int DATA_W = 16;
  localparam int PROG_W = 24;
  localparam int PAGE_W = 8;
  localparam int OFFS_W = 15;
  localparam int PROG_AW = PAGE_W + OFFS_W;
  localparam int CNT_W = 2;

  // ==========================================================================
  // Window geometry.
  localparam int WINDOW_BYTES = 32768;
  localparam int PAGE_WORDS = 16384;
  localparam int WIN_SEL_BIT = 15;
  localparam logic [DATA_AW-1:0] WINDOW_BASE = 16'h8000;

  // ==========================================================================
  // Extra instruction cycles for a window access.
  localparam logic [CNT_W-1:0] EXTRA_NONE = 2'h0;
  localparam logic [CNT_W-1:0] EXTRA_LIGHT = 2'h1;
  localparam logic [CNT_W-1:0] EXTRA_HEAVY = 2'h2;
  localparam logic [CNT_W-1:0] EXTRA_RPT_EDGE = 2'h2;
  localparam logic [CNT_W-1:0] EXTRA_RPT_FAST = 2'h0;

  // ==========================================================================
  // Reset values.
  localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;
  localparam logic [PROG_AW-1:0] PADDR_RST = 23'h000000;

  typedef enum logic {ST_IDLE, ST_WAIT} win_state_t;

endpackage : window_pkg

/* File: rtl/program_space_data_window.sv */
// Data-space window onto one page of program memory, with its cycle penalties.
// Assumes single-cycle synchronous data and program memories on mclk, and core
// request signals generated on mclk.
`timescale 1ns/100ps

module program_space_data_window (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic window_en,
  input wire logic [window_pkg::PAGE_W-1:0] window_page,
  input wire logic table_busy,
  input wire logic cpu_req,
  input wire logic [window_pkg::DATA_AW-1:0] cpu_addr,
  input wire logic light_ins,
  input wire logic in_repeat,
  input wire logic rpt_first,
  input wire logic rpt_last,
  input wire logic rpt_irq_exit,
  input wire logic rpt_irq_reenter,
  output logic cpu_busy,
  output logic cpu_ack,
  output logic [window_pkg::DATA_W-1:0] cpu_rdata,
  output logic cpu_xspace,
  output logic cpu_from_prog,
  output logic dmem_req,
  output logic [window_pkg::DATA_AW-1:0] dmem_addr,
  input wire logic [window_pkg::DATA_W-1:0] dmem_rdata,
  output logic pmem_req,
  output logic [window_pkg::PROG_AW-1:0] pmem_addr,
  input wire logic [window_pkg::PROG_W-1:0] pmem_rdata
);
  import window_pkg::*;

  // ==========================================================================
  // Internal state and its next values.
  win_state_t state_q;
  win_state_t state_d;
  logic take;
  logic done;
  logic refetch;
  logic hit_q;
  logic hit_d;
  logic xspace_q;
  logic xspace_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [PROG_AW-1:0] paddr_q;
  logic [PROG_AW-1:0] paddr_d;
  logic ack_q;
  logic ack_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic from_prog_q;
  logic from_prog_d;

  win_if w ();

  // ==========================================================================
  // Mapper hookup; it always looks at the live request.
  assign w.addr = cpu_addr;
  assign w.win_en = window_en;
  assign w.page = window_page;
  assign w.table_busy = table_busy;
  assign w.light_ins = light_ins;
  assign w.in_repeat = in_repeat;
  assign w.rpt_first = rpt_first;
  assign w.rpt_last = rpt_last;
  assign w.rpt_irq_exit = rpt_irq_exit;
  assign w.rpt_irq_reenter = rpt_irq_reenter;

  window_map u_map (
    .w(w.map)
  );

  // ==========================================================================
  // Request handshake.
  assign take = cpu_req && (state_q == ST_IDLE);
  assign done = (state_q == ST_WAIT) && (cnt_q == EXTRA_NONE);
  assign refetch = cpu_busy && hit_q && (cnt_q != EXTRA_NONE);
  assign cpu_busy = (state_q == ST_WAIT);

  // ==========================================================================
  // Memory ports. A window access refetches the same program address each penalty cycle.
  assign dmem_req = take && !w.hit;
  assign dmem_addr = cpu_addr;
  assign pmem_req = (take && w.hit) || refetch;
  assign pmem_addr = take ? w.prog_addr : paddr_q;

  // ==========================================================================
  // Sequencer.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Penalty counter, loaded with the extra cycles at the request.
  always_comb begin
    cnt_d = cnt_q;
    if (take) begin
      cnt_d = w.extra;
    end else if (cpu_busy && (cnt_q != EXTRA_NONE)) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= EXTRA_NONE;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================================
  // Latched request attributes.
  always_comb begin
    hit_d = hit_q;
    xspace_d = xspace_q;
    paddr_d = paddr_q;
    if (take) begin
      hit_d = w.hit;
      xspace_d = cpu_addr[WIN_SEL_BIT];
      paddr_d = w.prog_addr;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hit_q <= 1'b0;
      paddr_q <= PADDR_RST;
    end else begin
      hit_q <= hit_d;
      paddr_q <= paddr_d;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      xspace_q <= 1'b0;
    end else begin
      xspace_q <= xspace_d;
    end
  end

  // ==========================================================================
  // Answer: data captured the cycle after the last fetch, then a one-cycle ack.
  always_comb begin
    rdata_d = rdata_q;
    from_prog_d = from_prog_q;
    if (done) begin
      rdata_d = hit_q ? pmem_rdata[DATA_W-1:0] : dmem_rdata;
      from_prog_d = hit_q;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      from_prog_q <= 1'b0;
    end else begin
      from_prog_q <= from_prog_d;
    end
  end

  assign ack_d = done;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  assign cpu_ack = ack_q;
  assign cpu_rdata = rdata_q;
  assign cpu_xspace = xspace_q;
  assign cpu_from_prog = from_prog_q;

endmodule : program_space_data_window

/* File: rtl/window_map.sv */
// Address decode, program address forming and cycle-penalty decode for the window.
// Assumes its inputs are stable in the cycle a request is taken; purely combinational.
`timescale 1ns/100ps
module window_map (
  win_if.map w
);
  import window_pkg::*;

  // ==========================================================================
  // Decode of a window hit.
  always_comb begin
    w.hit = w.addr[WIN_SEL_BIT] & w.win_en & ~w.table_busy;
  end

  // ==========================================================================
  // Program address: page above the untouched low address bits.
  always_comb begin
    w.prog_addr = {w.page, w.addr[OFFS_W-1:0]};
  end

  // ==========================================================================
  // Extra cycles owed by the access.
  always_comb begin
    if (!w.hit) begin
      w.extra = EXTRA_NONE;
    end else if (!w.in_repeat) begin
      w.extra = w.light_ins ? EXTRA_LIGHT : EXTRA_HEAVY;
    end else if (w.rpt_first | w.rpt_last | w.rpt_irq_exit | w.rpt_irq_reenter) begin
      w.extra = EXTRA_RPT_EDGE;
    end else begin
      w.extra = EXTRA_RPT_FAST;
    end
  end

endmodule : window_map
